// >>> rtl/pdhc_pkg.sv
/*
  Shared constants for the position decoder: register word indices, bit
  positions, field widths, reset values and the write-sync state type.
  Assumes a 32-bit Avalon-MM slave addressed by word index.
*/
package pdhc_pkg;
  // ------------------------------------------------------------
  // register word indices
  // ------------------------------------------------------------
  localparam logic [5:0] A_CTRL = 6'h00;
  localparam logic [5:0] A_EVCTRL = 6'h01;
  localparam logic [5:0] A_IFLAG = 6'h02;
  localparam logic [5:0] A_STATUS = 6'h03;
  localparam logic [5:0] A_COUNT = 6'h04;
  localparam logic [5:0] A_CMP0 = 6'h05;
  localparam logic [5:0] A_CMP1 = 6'h06;
  localparam logic [5:0] A_LIMIT = 6'h07;
  localparam logic [5:0] A_FILTER = 6'h08;
  localparam logic [5:0] A_CMD = 6'h09;
  localparam logic [5:0] A_PRELOAD = 6'h19;

  // ------------------------------------------------------------
  // bit positions
  // ------------------------------------------------------------
  localparam int CTRL_EN = 0;
  localparam int CTRL_CNTMODE = 1;
  localparam int FL_WRAP = 0;
  localparam int FL_ERR = 1;
  localparam int FL_MZ = 2;
  localparam int ST_HALL = 0;
  localparam int ST_WIN = 1;
  localparam int CMD_UPDATE = 0;
  localparam int CMD_CLEAR = 1;

  // ------------------------------------------------------------
  // widths and reset values
  // ------------------------------------------------------------
  localparam int CW = 16;
  localparam int HW = 8;
  localparam int FW = 8;
  localparam logic [FW-1:0] PRELOAD_RST = 8'h00;
  localparam logic [CW-1:0] LIMIT_RST = 16'hffff;
  localparam logic [CW-1:0] CMP_RST = 16'h0000;
  localparam logic [2:0] HALL_BAD_LO = 3'h0;
  localparam logic [2:0] HALL_BAD_HI = 3'h7;
  localparam logic [HW-1:0] WIN_SAT = 8'hff;
  localparam logic [1:0] SYNC_STAGES = 2'h2;

  typedef enum logic [2:0] {
    PDHC_S_IDLE = 3'b001,
    PDHC_S_BUSY = 3'b010,
    PDHC_S_DONE = 3'b100
  } pdhc_sync_e;
endpackage

// >>> rtl/pdhc_sync.sv
/*
  Write-synchronization timer: a start pulse holds busy for SYNC_STAGES
  cycles, then gives one done cycle; the write is committed in the cycle after it.
  Assumes start is only raised while idle.
*/
`timescale 1ns/100ps
module pdhc_sync (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic start,
  output logic busy,
  output logic done
);
  pdhc_pkg::pdhc_sync_e state_q;
  logic [1:0] cnt_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= pdhc_pkg::PDHC_S_IDLE;
      cnt_q <= 2'h0;
    end else begin
      case (state_q)
        pdhc_pkg::PDHC_S_IDLE: begin
          if (start) begin
            state_q <= pdhc_pkg::PDHC_S_BUSY;
            cnt_q <= pdhc_pkg::SYNC_STAGES - 2'h1;
          end
        end
        pdhc_pkg::PDHC_S_BUSY: begin
          if (cnt_q == 2'h0) begin
            state_q <= pdhc_pkg::PDHC_S_DONE;
          end else begin
            cnt_q <= cnt_q - 2'h1;
          end
        end
        default: begin
          state_q <= pdhc_pkg::PDHC_S_IDLE;
        end
      endcase
    end
  end

  assign busy = (state_q == pdhc_pkg::PDHC_S_BUSY);
  assign done = (state_q == pdhc_pkg::PDHC_S_DONE);
endmodule // pdhc_sync

// >>> rtl/pdhc_top.sv
/*
  Position decoder: Hall-sensor checks, plain wrapping counter, input
  glitch filter with preload, Avalon-MM register slave with waitrequest.
  Assumes hall_in and count_tick are synchronous to clk_sys.
*/
// Register access over Avalon-MM was decided locally.
// How it works
// - illegal Hall code 000 or 111 sets the Hall fault flag.
// - compare-match-zero flag set when compare zero low bits equal Hall state.
// - that match may also pulse an event output if enabled.
// - on Hall change check window counter between upper halves, then clear it.
// - Hall change starts delay counter; hit on compare zero low half gives match.
// - any fault sets the summary error flag, with optional event.
// - each counter tick while counting is enabled clears, wraps or increments the count, unless a count write lands in the same cycle.
// - count rises by one per tick up to the limit, then wraps to zero.
// - a tick while at the limit with no clear pending sets the wrap flag, with optional event.
// - software count write accepted while running and beats tick or clear.
// - count starts at zero, or keeps written or held value across disable.
// - synchronized settings commit only after the sync delay completes.
// - update command copies the eight-bit preload into the active filter.
// - in counter mode the preload has no effect.
`timescale 1ns/100ps
module pdhc_top (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [2:0] hall_in,
  input wire logic count_tick,
  output logic evt_wrap,
  output logic evt_err,
  output logic evt_mz
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [1:0] ctrl_q;
  logic [2:0] evctrl_q;
  logic [2:0] iflag_q;
  logic [1:0] status_q;
  logic [pdhc_pkg::CW-1:0] count_q;
  logic [pdhc_pkg::CW-1:0] cmp0_q;
  logic [pdhc_pkg::CW-1:0] cmp1_q;
  logic [pdhc_pkg::CW-1:0] limit_q;
  logic [pdhc_pkg::FW-1:0] filter_q;
  logic [pdhc_pkg::FW-1:0] preload_q;
  logic clr_pend_q;
  logic [2:0] hall_q;
  logic [pdhc_pkg::HW-1:0] win_q;
  logic [pdhc_pkg::HW-1:0] dly_q;
  logic dly_run_q;
  logic ack_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic evt_wrap_q;
  logic evt_err_q;
  logic evt_mz_q;
  logic [2:0] filt_w;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  wire logic req = avs_read | avs_write;
  wire logic sel_ctrl = (avs_address == pdhc_pkg::A_CTRL);
  wire logic sel_evctrl = (avs_address == pdhc_pkg::A_EVCTRL);
  wire logic sel_iflag = (avs_address == pdhc_pkg::A_IFLAG);
  wire logic sel_status = (avs_address == pdhc_pkg::A_STATUS);
  wire logic sel_count = (avs_address == pdhc_pkg::A_COUNT);
  wire logic sel_cmp0 = (avs_address == pdhc_pkg::A_CMP0);
  wire logic sel_cmp1 = (avs_address == pdhc_pkg::A_CMP1);
  wire logic sel_limit = (avs_address == pdhc_pkg::A_LIMIT);
  wire logic sel_filter = (avs_address == pdhc_pkg::A_FILTER);
  wire logic sel_cmd = (avs_address == pdhc_pkg::A_CMD);
  wire logic sel_preload = (avs_address == pdhc_pkg::A_PRELOAD);
  wire logic [31:0] bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire logic [31:0] wbits = avs_writedata & bmask;
  // settings read by counter-domain logic in the original clocking scheme
  wire logic syncd = sel_ctrl | sel_count | sel_limit | sel_preload;
  logic sync_busy;
  logic sync_done;
  wire logic sync_start = avs_write & syncd & ~ack_q & ~sync_busy & ~sync_done;
  wire logic ack_d = req & ~ack_q & (~(avs_write & syncd) | sync_done);
  wire logic we = avs_write & ack_q; // commit on the edge the master sees the answer
  wire logic wr_ctrl = we & sel_ctrl;
  wire logic wr_evctrl = we & sel_evctrl;
  wire logic wr_iflag = we & sel_iflag;
  wire logic wr_status = we & sel_status;
  wire logic wr_count = we & sel_count;
  wire logic wr_cmp0 = we & sel_cmp0;
  wire logic wr_cmp1 = we & sel_cmp1;
  wire logic wr_limit = we & sel_limit;
  wire logic wr_cmd = we & sel_cmd;
  wire logic wr_preload = we & sel_preload;
  wire logic [15:0] m16 = bmask[15:0];
  wire logic [15:0] count_wv = (count_q & ~m16) | wbits[15:0];
  wire logic [15:0] cmp0_wv = (cmp0_q & ~m16) | wbits[15:0];
  wire logic [15:0] cmp1_wv = (cmp1_q & ~m16) | wbits[15:0];
  wire logic [15:0] limit_wv = (limit_q & ~m16) | wbits[15:0];

  pdhc_sync u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .start(sync_start),
    .busy(sync_busy),
    .done(sync_done)
  );

  // ------------------------------------------------------------
  // mode and input filter
  // ------------------------------------------------------------
  wire logic cnt_mode = ctrl_q[pdhc_pkg::CTRL_CNTMODE];
  wire logic hall_run = ctrl_q[pdhc_pkg::CTRL_EN] & ~cnt_mode;
  wire logic cnt_run = ctrl_q[pdhc_pkg::CTRL_EN] & cnt_mode;

  // a line must differ for more than filter_q cycles before it is taken
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_filt
      logic [pdhc_pkg::FW-1:0] fcnt_q;
      logic bit_q;
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          fcnt_q <= 8'h00;
          bit_q <= 1'b0;
        end else if (hall_in[gi] == bit_q) begin
          fcnt_q <= 8'h00;
        end else if (fcnt_q >= filter_q) begin
          bit_q <= hall_in[gi];
          fcnt_q <= 8'h00;
        end else begin
          fcnt_q <= fcnt_q + 8'h01;
        end
      end
      assign filt_w[gi] = bit_q;
    end
  endgenerate

  // ------------------------------------------------------------
  // hall checks
  // ------------------------------------------------------------
  // one check per code change
  wire logic hall_chg = hall_run & (filt_w != hall_q);
  wire logic hall_bad = hall_chg & ((filt_w == pdhc_pkg::HALL_BAD_LO) |
                                    (filt_w == pdhc_pkg::HALL_BAD_HI));
  wire logic cmp_hit = hall_chg & (filt_w == cmp0_q[2:0]);
  wire logic [7:0] win_lo = cmp0_q[15:8];
  wire logic [7:0] win_hi = cmp1_q[15:8];
  wire logic win_bad = hall_chg & ((win_q < win_lo) | (win_q > win_hi));
  wire logic dly_hit = hall_run & dly_run_q & ~hall_chg & (dly_q == cmp0_q[7:0]);
  wire logic err_set = hall_bad | win_bad;
  wire logic mz_set = cmp_hit | dly_hit;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hall_q <= 3'h0;
      win_q <= 8'h00;
      dly_q <= 8'h00;
      dly_run_q <= 1'b0;
    end else begin
      hall_q <= filt_w;
      if (hall_chg) begin
        win_q <= 8'h00;
        dly_q <= 8'h00;
        dly_run_q <= 1'b1;
      end else begin
        // saturate so a stalled rotor reads as too slow, not wrapped
        if (win_q != pdhc_pkg::WIN_SAT) begin
          win_q <= win_q + 8'h01;
        end
        if (dly_hit) begin
          dly_run_q <= 1'b0;
        end else if (dly_run_q) begin
          dly_q <= dly_q + 8'h01;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  wire logic tick_go = cnt_run & count_tick & ~wr_count;
  wire logic at_limit = (count_q == limit_q);
  wire logic tick_wrap = tick_go & ~clr_pend_q & at_limit;
  wire logic clr_req = wr_cmd & wbits[pdhc_pkg::CMD_CLEAR];

  // count only moves on ticks or writes
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count_q <= 16'h0000;
    end else if (wr_count) begin
      count_q <= count_wv;
    end else if (tick_go) begin
      if (clr_pend_q | at_limit) begin
        count_q <= 16'h0000;
      end else begin
        count_q <= count_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      clr_pend_q <= 1'b0;
    end else if (clr_req) begin
      clr_pend_q <= 1'b1;
    end else if (tick_go) begin
      clr_pend_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // flags and events
  // ------------------------------------------------------------
  // flag and status set and clear sources
  wire logic [2:0] fl_set = {mz_set, err_set, tick_wrap};
  wire logic [1:0] st_set = {win_bad, hall_bad};
  wire logic [2:0] fl_clr = wr_iflag ? wbits[2:0] : 3'h0;
  wire logic [1:0] st_clr = wr_status ? wbits[1:0] : 2'h0;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      iflag_q <= 3'h0;
      status_q <= 2'h0;
    end else begin
      iflag_q <= (iflag_q & ~fl_clr) | fl_set;
      status_q <= (status_q & ~st_clr) | st_set;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      evt_wrap_q <= 1'b0;
      evt_err_q <= 1'b0;
      evt_mz_q <= 1'b0;
    end else begin
      evt_wrap_q <= tick_wrap & evctrl_q[pdhc_pkg::FL_WRAP];
      evt_err_q <= err_set & evctrl_q[pdhc_pkg::FL_ERR];
      evt_mz_q <= mz_set & evctrl_q[pdhc_pkg::FL_MZ];
    end
  end

  // ------------------------------------------------------------
  // settings registers
  // ------------------------------------------------------------
  // update copies preload
  wire logic upd = wr_cmd & wbits[pdhc_pkg::CMD_UPDATE] & ~cnt_mode;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_q <= 2'h0;
      evctrl_q <= 3'h0;
      cmp0_q <= pdhc_pkg::CMP_RST;
      cmp1_q <= pdhc_pkg::CMP_RST;
      limit_q <= pdhc_pkg::LIMIT_RST;
      preload_q <= pdhc_pkg::PRELOAD_RST;
      filter_q <= pdhc_pkg::PRELOAD_RST;
    end else begin
      if (wr_ctrl & avs_byteenable[0]) ctrl_q <= avs_writedata[1:0];
      if (wr_evctrl & avs_byteenable[0]) evctrl_q <= avs_writedata[2:0];
      if (wr_cmp0) cmp0_q <= cmp0_wv;
      if (wr_cmp1) cmp1_q <= cmp1_wv;
      if (wr_limit) limit_q <= limit_wv;
      if (wr_preload & avs_byteenable[0]) preload_q <= avs_writedata[7:0];
      if (upd) filter_q <= preload_q;
    end
  end

  // ------------------------------------------------------------
  // read path and handshake
  // ------------------------------------------------------------
  wire logic [31:0] rd_w =
    sel_ctrl ? {30'h0, ctrl_q} :
    sel_evctrl ? {29'h0, evctrl_q} :
    sel_iflag ? {29'h0, iflag_q} :
    sel_status ? {30'h0, status_q} :
    sel_count ? {16'h0, count_q} :
    sel_cmp0 ? {16'h0, cmp0_q} :
    sel_cmp1 ? {16'h0, cmp1_q} :
    sel_limit ? {16'h0, limit_q} :
    sel_filter ? {24'h0, filter_q} :
    sel_preload ? {24'h0, preload_q} : 32'h0;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      ack_q <= ack_d;
      wait_q <= ~ack_d;
      if (ack_d & avs_read) begin
        rdata_q <= rd_w;
      end
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
  assign evt_wrap = evt_wrap_q;
  assign evt_err = evt_err_q;
  assign evt_mz = evt_mz_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  chk_hall_fault_set: assert property (hall_bad |=> status_q[0] && iflag_q[1])
    else $error("illegal hall code not flagged");
  chk_state_compare: assert property (cmp_hit |=> iflag_q[2])
    else $error("state match flag missing");
  chk_match_event: assert property (mz_set && evctrl_q[2] |=> evt_mz && iflag_q[2])
    else $error("match event missing");
  chk_window_clear: assert property (win_bad |=> status_q[1] && win_q == 8'h00)
    else $error("window fault or clear missing");
  chk_delay_start: assert property (hall_chg |=> dly_run_q && dly_q == 8'h00 ##1
    (!dly_run_q || dly_q == 8'h01 || $past(hall_chg)))
    else $error("delay counter not started");
  chk_err_event: assert property (err_set && evctrl_q[1] |=> evt_err && iflag_q[1])
    else $error("error event missing");
  chk_count_step: assert property (tick_go && !clr_pend_q && !at_limit |=> count_q == $past(count_q) + 16'h0001)
    else $error("count did not step");
  chk_count_wrap: assert property (tick_wrap |=> count_q == 16'h0000 && iflag_q[0])
    else $error("count did not wrap");
  chk_wrap_event: assert property (tick_wrap && evctrl_q[0] |=> evt_wrap)
    else $error("wrap event missing");
  chk_write_wins: assert property (wr_count |=> count_q == $past(count_wv))
    else $error("count write lost");
  chk_count_hold: assert property (!ctrl_q[0] && !wr_count |=> $stable(count_q))
    else $error("count moved while disabled");
  chk_sync_wait: assert property (sync_start |=> avs_waitrequest [*3] ##1 !avs_waitrequest)
    else $error("sync write latency wrong");
  chk_filter_load: assert property (upd |=> filter_q == $past(preload_q))
    else $error("filter not loaded");
  chk_filter_ignore: assert property (cnt_mode && !wr_ctrl |=> $stable(filter_q))
    else $error("filter changed in counter mode");
  chk_hall_once: assert property (hall_chg |=> hall_q == $past(filt_w))
    else $error("hall state not taken");
  chk_flag_sticky: assert property (iflag_q[1] && !(wr_iflag && wbits[1]) |=> iflag_q[1])
    else $error("error flag lost");

  cov_wrap: cover property (tick_wrap);
  cov_hall_bad: cover property (hall_bad);
  cov_delay_hit: cover property (dly_hit);
  cov_sync_write: cover property (sync_start ##4 !avs_waitrequest);
endmodule // pdhc_top

// >>> tb/pdhc_sensor_model.sv
/*
  Sensor-side partner: three hall lines and a counter tick, stepped by the bench.
  Assumes the bench raises step or tick_req for one clk_sys cycle per request.
*/
`timescale 1ns/100ps
module pdhc_sensor_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [2:0] next_code,
  input wire logic step,
  input wire logic tick_req,
  output logic [2:0] hall_in,
  output logic count_tick
);
  // ------------------------------------------------------------
  // sensor lines
  // ------------------------------------------------------------
  // lines stay driven at all times, like real push-pull sensors
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hall_in <= 3'h1;
      count_tick <= 1'b0;
    end else begin
      if (step) begin
        hall_in <= next_code;
      end
      count_tick <= tick_req;
    end
  end
endmodule // pdhc_sensor_model

// >>> tb/tb_top.sv
/*
  Self-checking bench for the position decoder: register bus, counter mode,
  filter preload and hall checks. Assumes the sensor model in its own file.
*/
`timescale 1ns/100ps
module tb_top;
  logic clk_sys;
  logic reset;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [2:0] hall_in;
  logic count_tick;
  logic evt_wrap;
  logic evt_err;
  logic evt_mz;
  logic [2:0] next_code;
  logic step;
  logic tick_req;
  int error_cnt;
  int check_count;
  int n_wrap;
  int n_err;
  int n_mz;

  pdhc_top DUT (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .hall_in(hall_in),
    .count_tick(count_tick), .evt_wrap(evt_wrap), .evt_err(evt_err), .evt_mz(evt_mz));
  pdhc_sensor_model sensor (.clk_sys(clk_sys), .reset(reset), .next_code(next_code), .step(step),
    .tick_req(tick_req), .hall_in(hall_in), .count_tick(count_tick));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // events are single-cycle pulses, so count them as they pass
  always @(posedge clk_sys) begin
    if (evt_wrap === 1'b1) n_wrap++;
    if (evt_err === 1'b1) n_err++;
    if (evt_mz === 1'b1) n_mz++;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q,
                     output int n);
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t bus timeout", $time);
      end_sim();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    int n;
    logic sy;
    sy = a == pdhc_pkg::A_CTRL || a == pdhc_pkg::A_COUNT || a == pdhc_pkg::A_LIMIT || a == pdhc_pkg::A_PRELOAD;
    bus(1'b1, a, d, q, n);
    // synced writes wait out the timer
    chk(32'(n), sy ? 32'h5 : 32'h2, "write wait");
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    int n;
    bus(1'b0, a, 32'h0, q, n);
    chk(q, exp, what);
  endtask

  task automatic tick();
    @(posedge clk_sys);
    tick_req <= 1'b1;
    @(posedge clk_sys);
    tick_req <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic hall(input logic [2:0] c);
    @(posedge clk_sys);
    next_code <= c;
    step <= 1'b1;
    @(posedge clk_sys);
    step <= 1'b0;
  endtask

  task automatic clr();
    wr(pdhc_pkg::A_STATUS, 32'h3);
    wr(pdhc_pkg::A_IFLAG, 32'h7);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd(pdhc_pkg::A_PRELOAD, 32'h0, "preload reset");
    rd(pdhc_pkg::A_LIMIT, 32'h0000ffff, "limit reset");
    rd(pdhc_pkg::A_COUNT, 32'h0, "count reset");
    wr(6'h3f, 32'h5a);
    rd(6'h3f, 32'h0, "unmapped read");
    $display("test reset done");
  endtask

  task automatic t_counter();
    int w0;
    wr(pdhc_pkg::A_LIMIT, 32'h3);
    wr(pdhc_pkg::A_EVCTRL, 32'h1);
    wr(pdhc_pkg::A_CTRL, 32'h3);
    w0 = n_wrap;
    for (int i = 1; i <= 3; i++) begin
      tick();
      rd(pdhc_pkg::A_COUNT, 32'(i), "count step");
    end
    tick();
    rd(pdhc_pkg::A_COUNT, 32'h0, "count wrap");
    rd(pdhc_pkg::A_IFLAG, 32'h1, "wrap flag");
    chk(32'(n_wrap - w0), 32'h1, "wrap event");
    tick();
    rd(pdhc_pkg::A_IFLAG, 32'h1, "flag sticky");
    wr(pdhc_pkg::A_IFLAG, 32'h1);
    rd(pdhc_pkg::A_IFLAG, 32'h0, "flag cleared");
    $display("test counter done");
  endtask

  task automatic t_write();
    wr(pdhc_pkg::A_COUNT, 32'h1);
    rd(pdhc_pkg::A_COUNT, 32'h1, "count written");
    tick();
    rd(pdhc_pkg::A_COUNT, 32'h2, "count after write");
    wr(pdhc_pkg::A_CTRL, 32'h2);
    tick();
    rd(pdhc_pkg::A_COUNT, 32'h2, "held while off");
    wr(pdhc_pkg::A_CTRL, 32'h3);
    rd(pdhc_pkg::A_COUNT, 32'h2, "kept on restart");
    wr(pdhc_pkg::A_CMD, 32'h2);
    tick();
    rd(pdhc_pkg::A_COUNT, 32'h0, "clear tick");
    wr(pdhc_pkg::A_IFLAG, 32'h7);
    $display("test write done");
  endtask

  task automatic t_filter();
    wr(pdhc_pkg::A_PRELOAD, 32'h5);
    rd(pdhc_pkg::A_PRELOAD, 32'h5, "preload rw");
    wr(pdhc_pkg::A_CMD, 32'h1);
    rd(pdhc_pkg::A_FILTER, 32'h0, "no update in counter");
    wr(pdhc_pkg::A_CTRL, 32'h1);
    wr(pdhc_pkg::A_CMD, 32'h1);
    rd(pdhc_pkg::A_FILTER, 32'h5, "filter updated");
    wr(pdhc_pkg::A_PRELOAD, 32'h0);
    wr(pdhc_pkg::A_CMD, 32'h1);
    rd(pdhc_pkg::A_FILTER, 32'h0, "filter back");
    $display("test filter done");
  endtask

  task automatic t_hall();
    int e0;
    int m0;
    // window 4..32 cycles, state match on 101, delay match far off at 253
    wr(pdhc_pkg::A_CMP0, 32'h04fd);
    wr(pdhc_pkg::A_CMP1, 32'h2000);
    wr(pdhc_pkg::A_EVCTRL, 32'h6);
    hall(3'h3);
    repeat (4) @(posedge clk_sys);
    clr();
    m0 = n_mz;
    hall(3'h5);
    repeat (4) @(posedge clk_sys);
    rd(pdhc_pkg::A_IFLAG, 32'h4, "state match");
    rd(pdhc_pkg::A_STATUS, 32'h0, "window ok");
    chk(32'(n_mz - m0), 32'h1, "match event");
    wr(pdhc_pkg::A_IFLAG, 32'h7);
    e0 = n_err;
    hall(3'h4);
    hall(3'h6);
    repeat (4) @(posedge clk_sys);
    rd(pdhc_pkg::A_STATUS, 32'h2, "window short");
    rd(pdhc_pkg::A_IFLAG, 32'h2, "error flag");
    chk(32'(n_err - e0), 32'h1, "error event");
    clr();
    repeat (6) @(posedge clk_sys);
    hall(3'h0);
    repeat (4) @(posedge clk_sys);
    rd(pdhc_pkg::A_STATUS, 32'h1, "illegal code");
    rd(pdhc_pkg::A_IFLAG, 32'h2, "hall error flag");
    hall(3'h3);
    repeat (4) @(posedge clk_sys);
    clr();
    m0 = n_mz;
    rd(pdhc_pkg::A_IFLAG, 32'h0, "no early delay match");
    repeat (260) @(posedge clk_sys);
    rd(pdhc_pkg::A_IFLAG, 32'h4, "delay match");
    chk(32'(n_mz - m0), 32'h1, "delay event");
    $display("test hall done");
  endtask

  initial begin
    reset = 1'b1;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    next_code = 3'h1;
    step = 1'b0;
    tick_req = 1'b0;
    error_cnt = 0;
    check_count = 0;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_counter();
    t_write();
    t_filter();
    t_hall();
    end_sim();
  end
endmodule // tb_top
